// ==== rtl/vcc_top.sv ====
/*
 * Valve channel control: per-channel enable state machine, local or
 * remote operation, command mapping, cable-break watch, PWM solenoid
 * drive with dither, power reduction, user characteristic, digital
 * outputs and internal signals, plus a plain register port.
 * Assumes command samples arrive on sys_clk_i; digital pins are async.
 */
// What this block does
// R1 - every channel owns its own enable state machine, changed independently
// R2 - a disabled channel drives no current into its solenoids
// R3 - mode changes accepted only while the channel is disabled
// R4 - at power-up every channel starts disabled
// R5 - enable from enable input locally, from host request remotely
// R6 - disable from enable input locally, from host request remotely
// R7 - two operating modes: local inputs or remote host control
// R8 - cable-break check only for live signal types with check switched on
// R9 - cable break when input is below lower or above upper limit
// R10 - break raises error; corrective action only if one is assigned
// R11 - break reported after about 100 ms; output follows faulty command meanwhile
// R12 - solenoids driven by 1000 Hz PWM with dither; measurement switchable
// R13 - each digital output follows a function or is forced low or high
// R14 - internal signals stay inside and can feed digital input functions
// R15 - command mode applies only in open-loop controller modes
// R16 - single-solenoid unipolar: 0..100 percent maps to 0..100 percent
// R17 - two-solenoid unipolar: 0..100 percent maps to -100..+100 percent
// R18 - bipolar: -100..+100 percent maps straight through
// R19 - direction input picks sign of a 0..100 percent command
// R20 - power reduction only for switching solenoid without measurement
// R21 - full current for reduction time after switch-on, then reduced value
// R22 - reduced value is a fraction of nominal, full scale equals nominal
// R23 - optional user characteristic switched on or off
`timescale 1ns/1ps
module vcc_top #(
    parameter int PWM_CYC = vcc_pkg::PWM_CYC,
    parameter int MS_CYC = vcc_pkg::MS_CYC,
    parameter int CB_CYC = vcc_pkg::CB_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // command samples, one per channel
    input wire logic [vcc_pkg::NCH-1:0][15:0] cmd_i,
    // digital pins
    input wire logic [1:0] din_i,
    output logic [1:0] dout_o,
    // solenoid drive, two per channel: positive then negative side
    output logic [2*vcc_pkg::NCH-1:0] sol_o,
    output logic [2*vcc_pkg::NCH-1:0] meas_en_o
);
    localparam logic [16:0] PWM_LAST = 17'(PWM_CYC - 1);
    localparam logic [16:0] MS_LAST = 17'(MS_CYC - 1);
    localparam logic [23:0] CB_LAST = 24'(CB_CYC - 1);
    localparam logic [31:0] PWM_FULL = 32'(PWM_CYC);
    localparam logic [31:0] DITH_AMP = 32'(PWM_CYC >> vcc_pkg::DITH_SH);
    localparam logic signed [16:0] CMD_ZERO_C = vcc_pkg::CMD_ZERO;

    vcc_pkg::vcc_state_type s;
    vcc_pkg::vcc_state_type n;
    logic [vcc_pkg::NCH-1:0] en_req_v;
    logic [vcc_pkg::NCH-1:0] cb_chk_v;
    logic [vcc_pkg::NCH-1:0] rng_v;
    logic [1:0] isig;
    logic [3:0] dsrc;

    function automatic logic ch_hit(input logic [7:0] a, input int ch, input logic [7:0] off);
        ch_hit = (a == vcc_pkg::CH_BASE + 8'(ch) * vcc_pkg::CH_STRIDE + off);
    endfunction

    function automatic logic signed [16:0] clamp(input logic signed [16:0] v,
                                                 input logic signed [16:0] lo,
                                                 input logic signed [16:0] hi);
        if (v < lo) begin
            clamp = lo;
        end else if (v > hi) begin
            clamp = hi;
        end else begin
            clamp = v;
        end
    endfunction

    always_comb begin
        logic [31:0] c;
        logic [31:0] nc;
        logic [3:0] cfg;
        logic v;
        logic ms_tick;
        logic act_hold;
        logic signed [16:0] x;
        logic signed [16:0] y;
        logic signed [16:0] pos;
        logic signed [16:0] ic;
        logic [31:0] mag;
        logic [31:0] duty;
        logic on;
        c = '0;
        nc = '0;
        cfg = '0;
        v = 1'b0;
        ms_tick = 1'b0;
        act_hold = 1'b0;
        x = '0;
        y = '0;
        pos = '0;
        ic = '0;
        mag = '0;
        duty = '0;
        on = 1'b0;
        n = s;
        en_req_v = '0;
        cb_chk_v = '0;
        rng_v = '0;
        isig = '0;
        n.rdata = '0;
        n.din_s1 = din_i;
        n.din_s2 = s.din_s1;

        // shared time base
        n.pwm_cnt = (s.pwm_cnt == PWM_LAST) ? 17'h00000 : s.pwm_cnt + 17'h00001;
        if (s.pwm_cnt == PWM_LAST) begin
            n.dith = ~s.dith;
        end
        ms_tick = (s.ms_cnt == MS_LAST);
        n.ms_cnt = ms_tick ? 17'h00000 : s.ms_cnt + 17'h00001;

        // digital outputs and their internal copies
        for (int k = 0; k < 2; k++) begin
            cfg = s.dcfg[k*vcc_pkg::DO_W +: vcc_pkg::DO_W];
            case (cfg[vcc_pkg::DO_FN +: 2])
                vcc_pkg::FN_LOW: v = 1'b0;  // [R13]
                vcc_pkg::FN_HIGH: v = 1'b1;  // [R13]
                vcc_pkg::FN_ACT: v = (s.ch[cfg[vcc_pkg::DO_CH]].st == vcc_pkg::ST_ACT);
                default: v = s.ch[cfg[vcc_pkg::DO_CH]].err;
            endcase
            isig[k] = v;  // [R14]
            // internal-only outputs keep the pin low
            n.dout[k] = v & ~cfg[vcc_pkg::DO_INT];  // [R14]
        end
        // internal signals sit above the pins, so one source index reaches both
        dsrc = {isig, s.din_s2};  // [R14]

        if (wr_i && addr_i == vcc_pkg::REG_DOUT) begin
            n.dcfg = wdata_i;
        end
        if (rd_i && addr_i == vcc_pkg::REG_DOUT) begin
            n.rdata = s.dcfg;
        end

        for (int i = 0; i < vcc_pkg::NCH; i++) begin  // [R1]
            c = s.ch[i].ctrl;
            en_req_v[i] = c[vcc_pkg::C_REMOTE] ? c[vcc_pkg::C_REQ]
                                               : dsrc[c[vcc_pkg::C_ENSEL +: 2]];  // [R7]
            act_hold = s.ch[i].err & c[vcc_pkg::C_ACT];  // [R10]

            case (s.ch[i].st)
                vcc_pkg::ST_DIS: begin
                    if (en_req_v[i] && !act_hold) begin
                        n.ch[i].st = vcc_pkg::ST_ACT;  // [R5]
                    end
                end
                vcc_pkg::ST_ACT: begin
                    if (!en_req_v[i] || act_hold) begin
                        n.ch[i].st = vcc_pkg::ST_DIS;  // [R6] [R10]
                    end
                end
                default: n.ch[i].st = vcc_pkg::ST_DIS;
            endcase

            // command mapping
            x = 17'(signed'(cmd_i[i]));
            pos = clamp(x, CMD_ZERO_C, vcc_pkg::CMD_FS);
            y = clamp(x, -vcc_pkg::CMD_FS, vcc_pkg::CMD_FS);  // [R18]
            if (c[vcc_pkg::C_OPEN]) begin  // [R15]
                case (vcc_pkg::vcc_mode_type'(c[vcc_pkg::C_MODE +: 2]))
                    vcc_pkg::MODE_UNI1: y = pos;  // [R16]
                    vcc_pkg::MODE_UNI2: y = (pos <<< 1) - vcc_pkg::CMD_FS;  // [R17]
                    vcc_pkg::MODE_DIR: y = dsrc[c[vcc_pkg::C_DIRSEL +: 2]] ? -pos : pos;  // [R19]
                    default: y = clamp(x, -vcc_pkg::CMD_FS, vcc_pkg::CMD_FS);  // [R18]
                endcase
            end
            n.ch[i].icmd = 16'(y);

            // cable break watch; the output keeps following the command meanwhile
            cb_chk_v[i] = c[vcc_pkg::C_CBON] && c[vcc_pkg::C_TYPE +: 3] >= vcc_pkg::SIG_VOLT
                          && c[vcc_pkg::C_TYPE +: 3] <= vcc_pkg::SIG_PWM;  // [R8]
            rng_v[i] = $signed(cmd_i[i]) < $signed(s.ch[i].limit[vcc_pkg::L_LO +: 16])
                       || $signed(cmd_i[i]) > $signed(s.ch[i].limit[vcc_pkg::L_HI +: 16]);  // [R9]
            if (wr_i && ch_hit(addr_i, i, vcc_pkg::CH_STAT) && wdata_i[vcc_pkg::S_ERR]) begin
                n.ch[i].err = 1'b0;
            end
            if (cb_chk_v[i] && rng_v[i]) begin
                if (s.ch[i].cb_cnt == CB_LAST) begin
                    n.ch[i].err = 1'b1;  // [R10] [R11]
                end else begin
                    n.ch[i].cb_cnt = s.ch[i].cb_cnt + 24'h000001;  // [R11]
                end
            end else begin
                n.ch[i].cb_cnt = 24'h000000;  // [R8]
            end

            // solenoid drive, from the registered internal command
            ic = 17'(signed'(s.ch[i].icmd));
            mag = (ic < CMD_ZERO_C) ? 32'(-ic) : 32'(ic);
            if (c[vcc_pkg::C_CHAR]) begin
                mag = (mag * 32'(s.ch[i].red[vcc_pkg::R_GAIN +: 8])) >> 4;  // [R23]
                if (mag > 32'(vcc_pkg::CMD_FS)) begin
                    mag = 32'(vcc_pkg::CMD_FS);
                end
            end
            on = (s.ch[i].st == vcc_pkg::ST_ACT) && (mag != 32'h0);  // [R2]
            duty = (mag * PWM_FULL) >> vcc_pkg::FS_SH;  // [R12]
            // dither bends the duty around its mean, staying inside the period
            if (s.dith && duty + DITH_AMP <= PWM_FULL) begin
                duty = duty + DITH_AMP;  // [R12]
            end else if (!s.dith && duty > DITH_AMP) begin
                duty = duty - DITH_AMP;  // [R12]
            end
            if (!on) begin
                n.ch[i].red_cnt = 16'h0000;
            end else if (ms_tick && s.ch[i].red_cnt < s.ch[i].red[vcc_pkg::R_TIME +: 16]) begin
                n.ch[i].red_cnt = s.ch[i].red_cnt + 16'h0001;  // [R21]
            end
            if (c[vcc_pkg::C_PR]) begin
                duty = (s.ch[i].red_cnt < s.ch[i].red[vcc_pkg::R_TIME +: 16]) ? PWM_FULL
                       : (PWM_FULL * 32'(s.ch[i].red[vcc_pkg::R_VAL +: 8])) >> 8;  // [R21] [R22]
            end
            n.sol[2*i] = on && (ic > CMD_ZERO_C) && (32'(s.pwm_cnt) < duty);  // [R2] [R12]
            n.sol[2*i+1] = on && (ic < CMD_ZERO_C) && (32'(s.pwm_cnt) < duty);  // [R2] [R12]
            n.meas[2*i +: 2] = {2{c[vcc_pkg::C_MEAS]}};  // [R12]

            // register writes
            if (wr_i && ch_hit(addr_i, i, vcc_pkg::CH_CTRL)) begin
                nc = wdata_i;
                if (s.ch[i].st == vcc_pkg::ST_ACT) begin
                    nc[vcc_pkg::C_MODE +: 2] = c[vcc_pkg::C_MODE +: 2];  // [R3]
                    nc[vcc_pkg::C_REMOTE] = c[vcc_pkg::C_REMOTE];  // [R3]
                end
                if (nc[vcc_pkg::C_MODE +: 2] == vcc_pkg::MODE_UNI1 && !nc[vcc_pkg::C_STD]) begin
                    nc[vcc_pkg::C_MODE +: 2] = c[vcc_pkg::C_MODE +: 2];  // [R16]
                end
                if (!nc[vcc_pkg::C_SWITCH] || nc[vcc_pkg::C_MEAS]) begin
                    nc[vcc_pkg::C_PR] = 1'b0;  // [R20]
                end
                n.ch[i].ctrl = nc;
            end
            if (wr_i && ch_hit(addr_i, i, vcc_pkg::CH_LIMIT)) begin
                n.ch[i].limit = wdata_i;
            end
            if (wr_i && ch_hit(addr_i, i, vcc_pkg::CH_RED)) begin
                n.ch[i].red = wdata_i;
            end

            // register reads
            if (rd_i && ch_hit(addr_i, i, vcc_pkg::CH_CTRL)) begin
                n.rdata = c;
            end
            if (rd_i && ch_hit(addr_i, i, vcc_pkg::CH_LIMIT)) begin
                n.rdata = s.ch[i].limit;
            end
            if (rd_i && ch_hit(addr_i, i, vcc_pkg::CH_RED)) begin
                n.rdata = s.ch[i].red;
            end
            if (rd_i && ch_hit(addr_i, i, vcc_pkg::CH_STAT)) begin
                n.rdata[vcc_pkg::S_ACT] = (s.ch[i].st == vcc_pkg::ST_ACT);
                n.rdata[vcc_pkg::S_ERR] = s.ch[i].err;
                n.rdata[vcc_pkg::S_PEND] = (s.ch[i].cb_cnt != 24'h000000);
                n.rdata[vcc_pkg::S_CMD +: 16] = s.ch[i].icmd;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            s <= '0;
            s.dcfg <= vcc_pkg::DOUT_RST;
            for (int i = 0; i < vcc_pkg::NCH; i++) begin
                s.ch[i].st <= vcc_pkg::ST_DIS;  // [R4]
                s.ch[i].ctrl <= vcc_pkg::CTRL_RST;
                s.ch[i].limit <= vcc_pkg::LIMIT_RST;
                s.ch[i].red <= vcc_pkg::RED_RST;
            end
        end else begin
            s <= n;
        end
    end

    assign rdata_o = s.rdata;
    assign dout_o = s.dout;
    assign sol_o = s.sol;
    assign meas_en_o = s.meas;

    default clocking dc @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    property p_dout_low;
        s.dcfg[vcc_pkg::DO_FN +: 2] == vcc_pkg::FN_LOW |=> !dout_o[0];
    endproperty
    a_dout_low: assert property (p_dout_low) else $error("forced-low output went high"); // [R13]
    property p_dout_high;
        s.dcfg[vcc_pkg::DO_FN +: 2] == vcc_pkg::FN_HIGH && !s.dcfg[vcc_pkg::DO_INT]
            |=> dout_o[0];
    endproperty
    a_dout_high: assert property (p_dout_high) else $error("forced-high output low"); // [R13]
    property p_dout_int;
        s.dcfg[vcc_pkg::DO_INT] |=> !dout_o[0];
    endproperty
    a_dout_int: assert property (p_dout_int) else $error("internal signal reached pin"); // [R14]

    for (genvar g = 0; g < vcc_pkg::NCH; g++) begin : g_chk
        sequence s_cb_due;
            cb_chk_v[g] && rng_v[g] && s.ch[g].cb_cnt == CB_LAST;
        endsequence
        property p_dis_off;
            s.ch[g].st == vcc_pkg::ST_DIS |=> sol_o[2*g +: 2] == 2'b00;
        endproperty
        a_dis_off: assert property (p_dis_off) else $error("disabled channel drives"); // [R2]
        property p_mode_lock;
            s.ch[g].st == vcc_pkg::ST_ACT |=>
                s.ch[g].ctrl[vcc_pkg::C_MODE +: 2] == $past(s.ch[g].ctrl[vcc_pkg::C_MODE +: 2]);
        endproperty
        a_mode_lock: assert property (p_mode_lock) else $error("mode changed while active"); // [R3]
        property p_poweron;
            @(posedge sys_clk_i) disable iff (1'b0) !resetn_i |=> s.ch[g].st == vcc_pkg::ST_DIS;
        endproperty
        a_poweron: assert property (p_poweron) else $error("channel not disabled at reset"); // [R4]
        property p_enable;
            s.ch[g].st == vcc_pkg::ST_DIS && en_req_v[g]
                && !(s.ch[g].err && s.ch[g].ctrl[vcc_pkg::C_ACT]) |=> s.ch[g].st == vcc_pkg::ST_ACT;
        endproperty
        a_enable: assert property (p_enable) else $error("enable request not taken"); // [R5]
        property p_disable;
            s.ch[g].st == vcc_pkg::ST_ACT && !en_req_v[g] |=> s.ch[g].st == vcc_pkg::ST_DIS;
        endproperty
        a_disable: assert property (p_disable) else $error("disable request not taken"); // [R6]
        property p_cb_gate;
            !cb_chk_v[g] |=> s.ch[g].cb_cnt == 24'h000000;
        endproperty
        a_cb_gate: assert property (p_cb_gate) else $error("break timer ran while off"); // [R8]
        property p_cb_due;
            s_cb_due |=> s.ch[g].err;
        endproperty
        a_cb_due: assert property (p_cb_due) else $error("cable break not reported"); // [R11]
        property p_pr_gate;
            s.ch[g].ctrl[vcc_pkg::C_PR] |-> s.ch[g].ctrl[vcc_pkg::C_SWITCH]
                && !s.ch[g].ctrl[vcc_pkg::C_MEAS];
        endproperty
        a_pr_gate: assert property (p_pr_gate) else $error("power reduction on wrong type"); // [R20]
        property p_uni2_zero;
            s.ch[g].ctrl[vcc_pkg::C_OPEN] && s.ch[g].ctrl[vcc_pkg::C_MODE +: 2] == vcc_pkg::MODE_UNI2
                && cmd_i[g] == 16'h0000 |=> s.ch[g].icmd == 16'hc000;
        endproperty
        a_uni2_zero: assert property (p_uni2_zero) else $error("unipolar zero not at -100"); // [R17]
        property p_cb_count;
            cb_chk_v[g] && rng_v[g] && s.ch[g].cb_cnt != CB_LAST |=>
                s.ch[g].cb_cnt == $past(s.ch[g].cb_cnt) + 24'h000001;
        endproperty
        a_cb_count: assert property (p_cb_count) else $error("break timer stalled"); // [R9]
        property p_cb_action;
            s.ch[g].err && s.ch[g].ctrl[vcc_pkg::C_ACT] |=> s.ch[g].st == vcc_pkg::ST_DIS;
        endproperty
        a_cb_action: assert property (p_cb_action) else $error("break action not taken"); // [R10]
        property p_meas;
            s.ch[g].ctrl[vcc_pkg::C_MEAS] |=> meas_en_o[2*g +: 2] == 2'b11;
        endproperty
        a_meas: assert property (p_meas) else $error("measure enable off its switch"); // [R12]
    end
endmodule

// ==== rtl/vcc_pkg.sv ====
/*
 * Shared constants and types for the valve channel control block:
 * register map, field positions, reset values, timing and state layout.
 * Assumes a 100 MHz system clock and 16-bit signed command samples
 * where 0x4000 stands for 100 percent.
 */
package vcc_pkg;
    localparam int NCH = 2;
    localparam int CLK_HZ = 100_000_000;
    localparam int PWM_HZ = 1000;
    localparam int PWM_CYC = CLK_HZ / PWM_HZ;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int CB_DELAY_MS = 100;
    localparam int CB_CYC = CB_DELAY_MS * MS_CYC;
    localparam int DITH_SH = 5;
    localparam int FS_SH = 14;
    localparam logic signed [16:0] CMD_FS = 17'sh04000;
    localparam logic signed [16:0] CMD_ZERO = 17'sh00000;

    // register offsets
    localparam logic [7:0] REG_DOUT = 8'h00;
    localparam logic [7:0] CH_BASE = 8'h10;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [7:0] CH_CTRL = 8'h00;
    localparam logic [7:0] CH_LIMIT = 8'h04;
    localparam logic [7:0] CH_RED = 8'h08;
    localparam logic [7:0] CH_STAT = 8'h0c;

    // digital output configuration, one nibble per output
    localparam int DO_FN = 0;
    localparam int DO_CH = 2;
    localparam int DO_INT = 3;
    localparam int DO_W = 4;
    localparam logic [1:0] FN_LOW = 2'h0;
    localparam logic [1:0] FN_HIGH = 2'h1;
    localparam logic [1:0] FN_ACT = 2'h2;
    localparam logic [1:0] FN_ERR = 2'h3;

    // channel control fields
    localparam int C_REQ = 0;
    localparam int C_MODE = 1;
    localparam int C_OPEN = 3;
    localparam int C_STD = 4;
    localparam int C_CBON = 5;
    localparam int C_TYPE = 6;
    localparam int C_MEAS = 9;
    localparam int C_SWITCH = 10;
    localparam int C_PR = 11;
    localparam int C_CHAR = 12;
    localparam int C_ENSEL = 13;
    localparam int C_DIRSEL = 15;
    localparam int C_ACT = 17;
    localparam int C_REMOTE = 18;

    // limit, reduction and status fields
    localparam int L_LO = 0;
    localparam int L_HI = 16;
    localparam int R_TIME = 0;
    localparam int R_VAL = 16;
    localparam int R_GAIN = 24;
    localparam int S_ACT = 0;
    localparam int S_ERR = 1;
    localparam int S_PEND = 2;
    localparam int S_CMD = 16;

    localparam logic [2:0] SIG_FIXED = 3'h0;
    localparam logic [2:0] SIG_VOLT = 3'h1;
    localparam logic [2:0] SIG_PWM = 3'h4;

    // reset values
    localparam logic [31:0] DOUT_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST = 32'h0000_001c;
    localparam logic [31:0] LIMIT_RST = 32'h7fff_8000;
    localparam logic [31:0] RED_RST = 32'h1080_0064;

    typedef enum logic [1:0] {
        MODE_UNI1 = 2'h0,
        MODE_UNI2 = 2'h1,
        MODE_BIP = 2'h2,
        MODE_DIR = 2'h3
    } vcc_mode_type;

    typedef enum logic [1:0] {
        ST_DIS = 2'b01,
        ST_ACT = 2'b10
    } vcc_st_type;

    typedef struct packed {
        vcc_st_type st;
        logic [31:0] ctrl;
        logic [31:0] limit;
        logic [31:0] red;
        logic err;
        logic [23:0] cb_cnt;
        logic [15:0] red_cnt;
        logic [15:0] icmd;
    } vcc_ch_type;

    typedef struct packed {
        vcc_ch_type [NCH-1:0] ch;
        logic [31:0] dcfg;
        logic [1:0] din_s1;
        logic [1:0] din_s2;
        logic [16:0] pwm_cnt;
        logic [16:0] ms_cnt;
        logic dith;
        logic [2*NCH-1:0] sol;
        logic [2*NCH-1:0] meas;
        logic [1:0] dout;
        logic [31:0] rdata;
    } vcc_state_type;
endpackage

// ==== rtl/vcc_top_note.sv ====
`timescale 1ns/1ps

// ==== verification/vcc_valve_model.sv ====
/*
 * Solenoid load model: accumulates on-cycles of channel 0's two gates.
 * Assumes gates are sampled on the rising edge of the system clock.
 */
`timescale 1ns/1ps
module vcc_valve_model (
    // clock and count clear
    input wire logic sys_clk_i,
    input wire logic clr_i,
    // channel 0 gates, positive then negative
    input wire logic [1:0] sol_i,
    // on-time per coil
    output int pos_on_o,
    output int neg_on_o
);
    // on-time stands in for coil current; no inductance modelled
    always @(posedge sys_clk_i) begin
        if (clr_i) begin
            pos_on_o <= 0;
            neg_on_o <= 0;
        end else begin
            pos_on_o <= pos_on_o + int'(sol_i[0] === 1'b1);
            neg_on_o <= neg_on_o + int'(sol_i[1] === 1'b1);
        end
    end
endmodule

// ==== verification/tb_vcc_top.sv ====
/*
 * Self-checking bench for the valve channel control block.
 * Assumes short count parameters: PWM 64, ms 16, break delay 40 cycles.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_vcc_top;
    logic sys_clk_i;
    logic resetn_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [31:0] rdata_o;
    logic [vcc_pkg::NCH-1:0][15:0] cmd_i;
    logic [1:0] din_i;
    logic [1:0] dout_o;
    logic [3:0] sol_o;
    logic [3:0] meas_en_o;
    logic clr;
    int pos_on;
    int neg_on;
    int failures = 0;
    int checks_done = 0;
    logic [15:0] r = 16'he856;
    logic [31:0] d;
    logic [7:0] ra[5] = '{8'h10, 8'h14, 8'h18, 8'h00, 8'hf0};
    logic [31:0] re[5] = '{32'h1c, 32'h7fff8000, 32'h10800064, 32'h0, 32'h0};
    int v, m, k, p, q, e;
    logic dir;

    vcc_top #(.PWM_CYC(64), .MS_CYC(16), .CB_CYC(40)) vcc_top_i (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmd_i(cmd_i), .din_i(din_i),
        .dout_o(dout_o), .sol_o(sol_o), .meas_en_o(meas_en_o));
    vcc_valve_model vcc_valve_model_i (.sys_clk_i(sys_clk_i), .clr_i(clr),
        .sol_i(sol_o[1:0]), .pos_on_o(pos_on), .neg_on_o(neg_on));

    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic int ecmd(int mo, int vi, logic dr);
        case (mo)
            1: return 2 * vi - (1 << vcc_pkg::FS_SH);
            3: return dr ? -vi : vi;
            default: return vi;
        endcase
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= w;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] w);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        w = rdata_o;
    endtask
    // first write drops the enable, so the mode write lands while disabled
    task automatic setc(input logic [7:0] a, input logic [31:0] w);
        wr(a, w);
        repeat (4) @(posedge sys_clk_i);
        wr(a, w);
        wr(a, w | 32'h1);
        repeat (4) @(posedge sys_clk_i);
    endtask
    task automatic count(input int n, output int a, output int b);
        @(posedge sys_clk_i);
        clr <= 1'b1;
        @(posedge sys_clk_i);
        clr <= 1'b0;
        repeat (n) @(posedge sys_clk_i);
        #1;
        a = pos_on;
        b = neg_on;
    endtask
    task automatic tally_and_finish;
        if (failures == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        failures++;
        tally_and_finish();
    end
    initial begin
        resetn_i = 1'b0;
        addr_i = '0;
        wdata_i = '0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        cmd_i = '0;
        din_i = '0;
        clr = 1'b0;
        repeat (16) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        foreach (ra[i]) begin
            rd(ra[i], d);
            `CHK("reset value", re[i], d)
        end
        for (k = 0; k < 2; k++) begin
            rd(8'h1c + 8'(16 * k), d);
            `CHK("active at reset", 1'b0, d[0])
        end
        for (m = 0; m < 4; m++) begin
            for (k = 0; k < 3; k++) begin
                r = lfsr(r);
                v = (m == 2) ? int'(r[14:0]) - 16384 : (m == 1 && k == 2) ? 0 : int'(r[13:0]);
                dir = (m == 3) && k[0];
                @(posedge sys_clk_i);
                din_i <= {1'b0, dir};
                cmd_i[0] <= 16'(v);
                setc(8'h10, 32'h40018 | 32'(m << 1));
                rd(8'h1c, d);
                `CHK("command", 16'(ecmd(m, v, dir)), d[31:16])
                `CHK("remote enable", 1'b1, d[0])
            end
        end
        wr(8'h10, 32'h4001b);
        rd(8'h10, d);
        `CHK("mode locked", 2'h3, d[2:1])
        @(posedge sys_clk_i);
        din_i <= 2'b01;
        repeat (5) @(posedge sys_clk_i);
        rd(8'h2c, d);
        `CHK("local enable", 1'b1, d[0])
        @(posedge sys_clk_i);
        din_i <= 2'b00;
        repeat (5) @(posedge sys_clk_i);
        rd(8'h2c, d);
        `CHK("local disable", 1'b0, d[0])
        rd(8'h1c, d);
        `CHK("other channel", 1'b1, d[0])
        @(posedge sys_clk_i);
        cmd_i[0] <= 16'h3000;
        wr(8'h10, 32'h4001e);
        count(128, p, q);
        `CHK("disabled drive", 0, p + q)
        `CHK("ch1 coils", 2'b00, sol_o[3:2])
        wr(8'h18, 32'h0880_0064);
        for (k = 0; k < 2; k++) begin
            @(posedge sys_clk_i);
            cmd_i[0] <= k ? 16'he000 : 16'h2000;
            setc(8'h10, k ? 32'h4101c : 32'h4021c);
            count(128, p, q);
            e = 64 >> k;
            `CHK("duty", 1'b1, (k ? q : p) inside {[e - 4 : e + 4]})
            `CHK("idle coil", 0, k ? p : q)
            `CHK("measure", {2'b00, {2{1'(1 - k)}}}, meas_en_o)
        end
        wr(8'h10, 32'h40e1c);
        rd(8'h10, d);
        `CHK("reduction refused", 1'b0, d[11])
        wr(8'h18, 32'h1080_0004);
        @(posedge sys_clk_i);
        cmd_i[0] <= 16'h4000;
        setc(8'h10, 32'h40c1c);
        count(40, p, q);
        `CHK("full current", 1'b1, p >= 36)
        repeat (60) @(posedge sys_clk_i);
        count(128, p, q);
        `CHK("reduced current", 1'b1, p inside {[58 : 70]})
        wr(8'h00, 32'h0000_0001);
        repeat (3) @(posedge sys_clk_i);
        #1;
        `CHK("dout fixed", 2'b01, dout_o)
        wr(8'h00, 32'h0000_0069);
        wr(8'h20, 32'h0000_401c);
        repeat (6) @(posedge sys_clk_i);
        rd(8'h2c, d);
        `CHK("internal enable", 1'b1, d[0])
        `CHK("dout internal", 2'b10, dout_o)
        wr(8'h14, 32'h1000_f000);
        @(posedge sys_clk_i);
        // at full scale, so the short window below always sees drive
        cmd_i[0] <= 16'h4000;
        setc(8'h10, 32'h4003c);
        repeat (60) @(posedge sys_clk_i);
        rd(8'h1c, d);
        `CHK("fixed type no check", 1'b0, d[1])
        wr(8'h10, 32'h4007d);
        repeat (25) @(posedge sys_clk_i);
        rd(8'h1c, d);
        `CHK("break latency", 1'b0, d[1])
        count(8, p, q);
        `CHK("drive meanwhile", 1'b1, p > 0)
        repeat (20) @(posedge sys_clk_i);
        rd(8'h1c, d);
        `CHK("break error", 1'b1, d[1])
        `CHK("no action", 1'b1, d[0])
        wr(8'h10, 32'h6007d);
        repeat (4) @(posedge sys_clk_i);
        rd(8'h1c, d);
        `CHK("break action", 1'b0, d[0])
        @(posedge sys_clk_i);
        cmd_i[0] <= 16'h0800;
        wr(8'h1c, 32'h2);
        rd(8'h1c, d);
        `CHK("break cleared", 1'b0, d[1])
        tally_and_finish();
    end
endmodule
